// ---- slmc_fifo.sv ----
`timescale 1ns/100ps
module slmc_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 4
) (
    input  wire logic             mclk_in,
    input  wire logic             rst_in,
    input  wire logic             ce_in,
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic      [WIDTH-1:0] out_data_out
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wptr_q;
    logic [AW-1:0]    rptr_q;
    logic [AW:0]      count_q;
    logic             push;
    logic             pop;

    assign in_ready_out  = (count_q != (AW+1)'(DEPTH));
    assign out_valid_out = (count_q != '0);
    assign push = in_valid_in && in_ready_out && ce_in;
    assign pop  = out_valid_out && out_ready_in && ce_in;
    assign out_data_out = mem_q[rptr_q];

    always_ff @(posedge mclk_in)
    begin
        if (push)
        begin
            mem_q[wptr_q] <= in_data_in;
        end
    end

    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            wptr_q  <= '0;
            rptr_q  <= '0;
            count_q <= '0;
        end
        else
        begin
            if (push)
            begin
                wptr_q <= (wptr_q == AW'(DEPTH-1)) ? '0 : wptr_q + 1'b1;
            end
            if (pop)
            begin
                rptr_q <= (rptr_q == AW'(DEPTH-1)) ? '0 : rptr_q + 1'b1;
            end
            count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// ---- slmc_pkg.sv ----
package slmc_pkg;

    // register indices (byte address = index, 8-bit port)
    localparam logic [7:0] ADDR_TEST_PATTERN = 8'h02;
    localparam logic [7:0] ADDR_MF_CTRL      = 8'h03;
    localparam logic [7:0] ADDR_SCRAMBLER    = 8'h05;
    localparam logic [7:0] ADDR_MF_LENGTH    = 8'h06;
    localparam logic [7:0] ADDR_BURST_CTRL   = 8'h17;
    localparam logic [7:0] ADDR_LINK_CTRL    = 8'h00;
    localparam logic [7:0] ADDR_STATUS       = 8'h07;

    localparam logic [7:0] RESET_VALUE = 8'h00;

    // field positions
    localparam int TP_SEL_LSB     = 5;
    localparam int TP_RPAT_BIT    = 4;
    localparam int TP_MASK_BIT    = 3;
    localparam int MF_PRESET_BIT  = 7;
    localparam int MF_VALUE_LSB   = 2;
    localparam int MF_DELAY_LSB   = 0;
    localparam int SCR_EN_BIT     = 7;
    localparam int LC_CUSTOM_K    = 7;
    localparam int LC_SUPPRESS    = 0;

    localparam logic [2:0] TP_NORMAL = 3'h0;
    localparam logic [2:0] TP_D215   = 3'h1;
    localparam logic [2:0] TP_K285   = 3'h2;
    localparam logic [2:0] TP_ILAS   = 3'h3;
    localparam logic [2:0] TP_RPAT   = 3'h4;

    localparam logic [4:0] MF_DEFAULT_K_M1 = 5'h04;
    localparam logic [4:0] MF_SYNC_END     = 5'h1F;
    localparam int         RPAT_LEN        = 12;
    localparam logic [1:0] ILAS_MULTIFRAMES = 2'h3;

    localparam logic [7:0] CH_K285 = 8'hBC;
    localparam logic [7:0] CH_K283 = 8'h7C;
    localparam logic [7:0] CH_K280 = 8'h1C;
    localparam logic [7:0] CH_D215 = 8'hB5;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_CGS,
        ST_DELAY,
        ST_ILAS,
        ST_DATA
    } slmc_state_e;

    typedef struct packed {
        logic [7:0] data;
        logic       is_k;
    } slmc_sym_s;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } slmc_bus_s;

endpackage

// ---- slmc_rx_model.sv ----
`timescale 1ns/100ps
module slmc_rx
    import slmc_pkg::*;
(
    input  wire logic                mclk_in,
    input  wire logic                rst_in,
    input  wire logic                want_in,
    input  wire logic                ref_in,
    input  wire logic                stall_in,
    input  wire logic                slow_in,
    input  wire logic                valid_in,
    input  wire slmc_pkg::slmc_sym_s sym_in,
    output logic                     sync_out,
    output logic                     sysref_out,
    output logic                     tick_out,
    output logic                     ready_out,
    output logic                     got_out,
    output slmc_pkg::slmc_sym_s      got_sym_out
);
    logic [1:0] div_q;
    logic       ref_q;

    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            div_q <= 2'h0;
            ref_q <= 1'b0;
            sync_out <= 1'b0;
            sysref_out <= 1'b0;
            tick_out <= 1'b0;
            ready_out <= 1'b0;
            got_out <= 1'b0;
            got_sym_out <= '0;
        end
        else
        begin
            div_q <= div_q + 2'h1;
            sync_out <= want_in;
            tick_out <= div_q == 2'h3;
            ref_q <= ref_in || (ref_q && div_q != 2'h1);
            sysref_out <= ref_q && div_q == 2'h1;
            // slow mode accepts every other cycle
            ready_out <= !stall_in && (!slow_in || div_q[0]);
            got_out <= valid_in && ready_out;
            got_sym_out <= sym_in;
        end
    end
endmodule

// ---- slmc_top.sv ----
// Local design decision: strobed register access.
`timescale 1ns/100ps
// Overview of operation
// - selector 0/1/2: samples, D21.5, K28.5
// - selector 3: K28.5 then repeated alignment
// - selector 4: twelve-octet RPAT pattern
// - flip RPAT disparity only in mode 4
// - writing mask-clear bit resets multiframe mask
// - preset enable selects programmable start value
// - SYSREF resets counter to zero normally
// - end CGS when counter reaches 31 or the multiframe wraps
// - preset value loaded on SYSREF when enabled
// - delay alignment start zero to three multiframes
// - scrambler enable bit steers scrambling
// - frames per multiframe is field plus one
// - five frames unless custom length enabled
// - suppress bit skips alignment after SYNC
module slmc_top
    import slmc_pkg::*;
(
    input  wire logic             mclk_in,
    input  wire logic             rst_in,
    input  wire logic             ce_in,
    input  wire slmc_pkg::slmc_bus_s bus_in,
    output logic      [7:0]       rdata_out,
    input  wire logic             sync_req_in,
    input  wire logic             sysref_in,
    input  wire logic             frame_tick_in,
    input  wire logic [7:0]       sample_in,
    input  wire logic             sample_valid_in,
    output logic                  sample_ready_out,
    output slmc_pkg::slmc_sym_s   sym_out,
    output logic                  sym_valid_out,
    input  wire logic             sym_ready_in,
    output logic                  scramble_en_out,
    output logic                  rpat_disparity_flip_out,
    output logic                  mf_boundary_out,
    output logic      [4:0]       mf_count_out
);
    import slmc_pkg::*;

    logic [7:0]  tp_q;
    logic [7:0]  mf_q;
    logic [7:0]  scr_q;
    logic [7:0]  len_q;
    logic [7:0]  burst_q;
    logic [7:0]  link_q;
    logic [7:0]  rdata_q;
    logic [4:0]  mf_cnt_q;
    logic        mask_q;
    logic [1:0]  dly_q;
    logic [1:0]  ilas_mf_q;
    logic [3:0]  rpat_idx_q;
    logic        frame_q;
    logic        lead_k_q;
    slmc_state_e state_q;
    slmc_sym_s   sym_d;
    logic        gen_valid;
    logic        fifo_ready;
    logic        adv;
    logic [2:0]  link_test_pattern_sel;
    logic        multiframe_preset_en;
    logic [4:0]  multiframe_preset_value;
    logic [1:0]  align_seq_delay;
    logic        align_seq_suppress;
    logic [4:0]  k_m1;
    logic        mf_wrap;
    logic [4:0]  mf_start;
    logic        slot_is_data;
    logic [7:0]  rpat_oct;
    logic [8:0]  fifo_out;

    assign link_test_pattern_sel   = tp_q[TP_SEL_LSB +: 3];
    assign multiframe_preset_en    = mf_q[MF_PRESET_BIT];
    assign multiframe_preset_value = mf_q[MF_VALUE_LSB +: 5];
    assign align_seq_delay         = mf_q[MF_DELAY_LSB +: 2];
    assign align_seq_suppress      = link_q[LC_SUPPRESS];
    // stall generation whenever the fifo is full
    assign adv = ce_in && fifo_ready;

    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            tp_q    <= RESET_VALUE;
            mf_q    <= RESET_VALUE;
            scr_q   <= RESET_VALUE;
            len_q   <= RESET_VALUE;
            burst_q <= RESET_VALUE;
            link_q  <= RESET_VALUE;
        end
        else if (ce_in && bus_in.wr)
        begin
            unique case (bus_in.addr)
                ADDR_TEST_PATTERN: tp_q    <= bus_in.wdata & 8'hF8;
                ADDR_MF_CTRL:      mf_q    <= bus_in.wdata;
                ADDR_SCRAMBLER:    scr_q   <= bus_in.wdata & 8'h80;
                ADDR_MF_LENGTH:    len_q   <= bus_in.wdata & 8'h1F;
                ADDR_BURST_CTRL:   burst_q <= bus_in.wdata & 8'hD8;
                ADDR_LINK_CTRL:    link_q  <= bus_in.wdata & 8'h81;
                default:           ;
            endcase
        end
    end

    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            rdata_q <= 8'h00;
        end
        else if (ce_in)
        begin
            rdata_q <= 8'h00;
            if (bus_in.rd)
            begin
                unique case (bus_in.addr)
                    ADDR_TEST_PATTERN: rdata_q <= tp_q;
                    ADDR_MF_CTRL:      rdata_q <= mf_q;
                    ADDR_SCRAMBLER:    rdata_q <= scr_q;
                    ADDR_MF_LENGTH:    rdata_q <= len_q;
                    ADDR_BURST_CTRL:   rdata_q <= burst_q;
                    ADDR_LINK_CTRL:    rdata_q <= link_q;
                    ADDR_STATUS:       rdata_q <= {mf_cnt_q, mask_q,
                                                   state_q == ST_DATA,
                                                   state_q == ST_CGS};
                    default:           rdata_q <= 8'h00;
                endcase
            end
        end
    end
    assign rdata_out = rdata_q;

    assign scramble_en_out = scr_q[SCR_EN_BIT];
    assign rpat_disparity_flip_out = tp_q[TP_RPAT_BIT] &&
                                     (link_test_pattern_sel == TP_RPAT);

    assign k_m1 = link_q[LC_CUSTOM_K] ? len_q[4:0] : MF_DEFAULT_K_M1;
    assign mf_wrap = frame_tick_in && (mf_cnt_q >= k_m1);
    assign mf_start = multiframe_preset_en ? multiframe_preset_value : 5'h00;

    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            mask_q <= 1'b0;
        end
        else if (ce_in)
        begin
            // a sysref in the clearing cycle keeps the mask set
            if (sysref_in)
            begin
                mask_q <= 1'b1;
            end
            else if (bus_in.wr && bus_in.addr == ADDR_TEST_PATTERN &&
                     bus_in.wdata[TP_MASK_BIT])
            begin
                mask_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            mf_cnt_q <= 5'h00;
            frame_q  <= 1'b0;
        end
        else if (ce_in)
        begin
            frame_q <= mf_wrap;
            if (sysref_in)
            begin
                mf_cnt_q <= mf_start;
            end
            else if (frame_tick_in)
            begin
                mf_cnt_q <= mf_wrap ? 5'h00 : mf_cnt_q + 5'h01;
            end
        end
    end
    assign mf_count_out    = mf_cnt_q;
    assign mf_boundary_out = frame_q;

    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            state_q   <= ST_IDLE;
            dly_q     <= 2'h0;
            ilas_mf_q <= 2'h0;
        end
        else if (ce_in)
        begin
            if (sync_req_in)
            begin
                state_q <= ST_CGS;
            end
            else
            begin
                unique case (state_q)
                    ST_IDLE: state_q <= ST_DATA;
                    ST_CGS:
                    begin
                        // suppress alignment
                        // short multiframes never reach 31, so wrap ends it
                        if (mf_cnt_q == MF_SYNC_END || mf_wrap)
                        begin
                            dly_q   <= align_seq_delay;
                            state_q <= align_seq_suppress ? ST_DATA :
                                       (align_seq_delay != 2'h0) ? ST_DELAY
                                                                 : ST_ILAS;
                            ilas_mf_q <= 2'h0;
                        end
                    end
                    ST_DELAY:
                    begin
                        if (mf_wrap)
                        begin
                            dly_q <= dly_q - 2'h1;
                            if (dly_q == 2'h1)
                            begin
                                state_q <= ST_ILAS;
                            end
                        end
                    end
                    ST_ILAS:
                    begin
                        if (mf_wrap)
                        begin
                            ilas_mf_q <= ilas_mf_q + 2'h1;
                            if (ilas_mf_q == ILAS_MULTIFRAMES)
                            begin
                                state_q <= ST_DATA;
                            end
                        end
                    end
                    ST_DATA: state_q <= ST_DATA;
                endcase
            end
        end
    end

    always_comb
    begin
        unique case (rpat_idx_q)
            4'h0:    rpat_oct = 8'hBE;
            4'h1:    rpat_oct = 8'hD7;
            4'h2:    rpat_oct = 8'h23;
            4'h3:    rpat_oct = 8'h47;
            4'h4:    rpat_oct = 8'h6B;
            4'h5:    rpat_oct = 8'h8F;
            4'h6:    rpat_oct = 8'hB3;
            4'h7:    rpat_oct = 8'h14;
            4'h8:    rpat_oct = 8'h5E;
            4'h9:    rpat_oct = 8'hFB;
            4'hA:    rpat_oct = 8'h35;
            4'hB:    rpat_oct = 8'h59;
            default: rpat_oct = 8'h00;
        endcase
    end

    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            rpat_idx_q <= 4'h0;
        end
        else if (adv && link_test_pattern_sel == TP_RPAT)
        begin
            rpat_idx_q <= (rpat_idx_q == 4'(RPAT_LEN - 1)) ? 4'h0
                                                           : rpat_idx_q + 4'h1;
        end
    end

    // one k28.5 leads the repeated alignment
    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            lead_k_q <= 1'b0;
        end
        else if (ce_in)
        begin
            if (bus_in.wr && bus_in.addr == ADDR_TEST_PATTERN)
            begin
                lead_k_q <= (bus_in.wdata[TP_SEL_LSB +: 3] == TP_ILAS);
            end
            else if (fifo_ready)
            begin
                lead_k_q <= 1'b0;
            end
        end
    end

    assign slot_is_data = (state_q == ST_DATA) &&
                          (link_test_pattern_sel == TP_NORMAL);
    assign sample_ready_out = slot_is_data && fifo_ready && ce_in;

    always_comb
    begin
        sym_d     = '{data: sample_in, is_k: 1'b0};
        gen_valid = 1'b1;
        unique case (link_test_pattern_sel)
            TP_D215: sym_d = '{data: CH_D215, is_k: 1'b0};
            TP_K285: sym_d = '{data: CH_K285, is_k: 1'b1};
            TP_ILAS:
            begin
                if (state_q == ST_CGS || lead_k_q)
                begin
                    sym_d = '{data: CH_K285, is_k: 1'b1};
                end
                else
                begin
                    sym_d = '{data: (frame_tick_in ? CH_K280 : CH_K283),
                              is_k: 1'b1};
                end
            end
            TP_RPAT: sym_d = '{data: rpat_oct, is_k: 1'b0};
            default:
            begin
                if (state_q == ST_CGS || state_q == ST_DELAY)
                begin
                    sym_d = '{data: CH_K285, is_k: 1'b1};
                end
                else if (state_q == ST_ILAS)
                begin
                    sym_d = '{data: (frame_tick_in ? CH_K280 : CH_K283),
                              is_k: 1'b1};
                end
                else
                begin
                    gen_valid = sample_valid_in && state_q == ST_DATA;
                end
            end
        endcase
    end

    // four entries ride out a half-rate receiver before stalling
    slmc_fifo #(
        .WIDTH (9),
        .DEPTH (4)
    ) u_fifo (
        .mclk_in       (mclk_in),
        .rst_in        (rst_in),
        .ce_in         (ce_in),
        .in_valid_in   (gen_valid),
        .in_ready_out  (fifo_ready),
        .in_data_in    (sym_d),
        .out_valid_out (sym_valid_out),
        .out_ready_in  (sym_ready_in),
        .out_data_out  (fifo_out)
    );
    assign sym_out = fifo_out;
endmodule

// ---- slmc_top_assertions.sv ----
`timescale 1ns/100ps
module slmc_chk
    import slmc_pkg::*;
(
    input wire logic                mclk_in,
    input wire logic                rst_in,
    input wire logic                ce_in,
    input wire slmc_pkg::slmc_bus_s bus_in,
    input wire logic                sysref_in,
    input wire logic                frame_tick_in,
    input wire logic                scramble_en_out,
    input wire logic                rpat_disparity_flip_out,
    input wire logic                mf_boundary_out,
    input wire logic [4:0]          mf_count_out
);
    logic [7:0] tp_q;
    logic [7:0] mf_q;
    logic [4:0] len_q;
    logic       ck_q;
    logic [4:0] kmax;
    logic       quiet;

    assign kmax = ck_q ? len_q : MF_DEFAULT_K_M1;
    assign quiet = ce_in && !sysref_in && !bus_in.wr;

    // shadow of the registers the outputs depend on
    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            tp_q <= 8'h00;
            mf_q <= 8'h00;
            len_q <= 5'h00;
            ck_q <= 1'b0;
        end
        else if (ce_in && bus_in.wr)
        begin
            if (bus_in.addr == ADDR_TEST_PATTERN)
                tp_q <= bus_in.wdata;
            if (bus_in.addr == ADDR_MF_CTRL)
                mf_q <= bus_in.wdata;
            if (bus_in.addr == ADDR_MF_LENGTH)
                len_q <= bus_in.wdata[4:0];
            if (bus_in.addr == ADDR_LINK_CTRL)
                ck_q <= bus_in.wdata[LC_CUSTOM_K];
        end
    end

    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (rst_in);

    sequence s_step;
        frame_tick_in && quiet && mf_count_out < kmax;
    endsequence
    sequence s_wrap;
        frame_tick_in && quiet && !mf_q[7] && mf_count_out == kmax;
    endsequence

    scramble_bit_a: assert property (
        ce_in && bus_in.wr && bus_in.addr == ADDR_SCRAMBLER
        |=> scramble_en_out == $past(bus_in.wdata[7]))
        else $error("scrambler enable does not follow its bit");
    rpat_flip_a: assert property (
        rpat_disparity_flip_out == (tp_q[7:5] == TP_RPAT && tp_q[4]))
        else $error("disparity flip outside pattern mode 4");
    sysref_zero_a: assert property (
        ce_in && sysref_in && !mf_q[7] |=> mf_count_out == 5'h00)
        else $error("counter not zeroed by sysref");
    sysref_preset_a: assert property (
        ce_in && sysref_in && mf_q[7]
        |=> mf_count_out == $past(mf_q[6:2]))
        else $error("counter not preset by sysref");
    count_step_a: assert property (
        s_step |=> mf_count_out == $past(mf_count_out) + 5'h01)
        else $error("counter did not advance on frame");
    count_wrap_a: assert property (
        s_wrap |=> mf_count_out == 5'h00)
        else $error("counter did not wrap at frame count");
    boundary_mark_a: assert property (
        s_wrap |-> ##[1:2] mf_boundary_out)
        else $error("no boundary pulse after wrap");
    count_hold_a: assert property (
        !frame_tick_in && !sysref_in |=> $stable(mf_count_out))
        else $error("counter moved without frame or sysref");
endmodule

bind slmc_top slmc_chk slmc_chk_inst (
    .mclk_in,
    .rst_in,
    .ce_in,
    .bus_in,
    .sysref_in,
    .frame_tick_in,
    .scramble_en_out,
    .rpat_disparity_flip_out,
    .mf_boundary_out,
    .mf_count_out
);

// ---- test_serial_link_multiframe_control.sv ----
`timescale 1ns/100ps
module test_serial_link_multiframe_control;
    import slmc_pkg::*;
    typedef struct {
        logic [7:0] a;
        logic [7:0] d;
        logic [7:0] r;
        int         k;
        slmc_sym_s  s;
    } slmc_row_s;
    logic       mclk_in, rst_in, ce_in, sync, sref, tick, sv, srdy;
    logic       svld, rdy, scr, flip, bnd, want, req, stall, slow, got;
    logic [7:0] rdata, smp, v;
    logic [4:0] cnt, c;
    slmc_bus_s  bus;
    slmc_sym_s  sym, gs, s0;
    int         num_errors, total_checks, nb;
    logic       il;
    slmc_row_s  rows[11] = '{
        '{ADDR_SCRAMBLER, 8'hFF, 8'h80, 0, 9'h000},
        '{ADDR_SCRAMBLER, 8'h00, 8'h00, 0, 9'h000},
        '{ADDR_MF_LENGTH, 8'hFF, 8'h1F, 0, 9'h000},
        '{ADDR_MF_CTRL, 8'hFF, 8'hFF, 0, 9'h000},
        '{ADDR_MF_CTRL, 8'h00, 8'h00, 0, 9'h000},
        '{ADDR_TEST_PATTERN, 8'h20, 8'h20, 1, {CH_D215, 1'b0}},
        '{ADDR_TEST_PATTERN, 8'h40, 8'h40, 1, {CH_K285, 1'b1}},
        '{ADDR_TEST_PATTERN, 8'h60, 8'h60, 2, 9'h000},
        '{ADDR_TEST_PATTERN, 8'h90, 8'h90, 3, 9'h000},
        '{ADDR_TEST_PATTERN, 8'h38, 8'h38, 0, 9'h000},
        '{8'h09, 8'hFF, 8'h00, 0, 9'h000}
    };

    slmc_top slmc_top_inst (.mclk_in, .rst_in, .ce_in, .bus_in(bus),
        .rdata_out(rdata), .sync_req_in(sync), .sysref_in(sref),
        .frame_tick_in(tick), .sample_in(smp), .sample_valid_in(sv),
        .sample_ready_out(srdy), .sym_out(sym), .sym_valid_out(svld),
        .sym_ready_in(rdy), .scramble_en_out(scr),
        .rpat_disparity_flip_out(flip), .mf_boundary_out(bnd),
        .mf_count_out(cnt));
    slmc_rx slmc_rx_inst (.mclk_in, .rst_in, .want_in(want),
        .ref_in(req), .stall_in(stall), .slow_in(slow), .valid_in(svld),
        .sym_in(sym), .sync_out(sync), .sysref_out(sref), .tick_out(tick),
        .ready_out(rdy), .got_out(got), .got_sym_out(gs));

    initial
    begin
        mclk_in = 1'b0;
        forever #2.5 mclk_in = !mclk_in;
    end

    task automatic check(input logic [8:0] g, input logic [8:0] e);
        total_checks++;
        if (g !== e)
        begin
            num_errors++;
            $display("wrong value t=%0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge mclk_in);
        bus.wr <= 1'b0;
        @(posedge mclk_in);
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        bus <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge mclk_in);
        bus.rd <= 1'b0;
        @(negedge mclk_in);
        q = rdata;
        @(posedge mclk_in);
    endtask

    task automatic nxt;
        repeat (60)
        begin
            @(negedge mclk_in);
            if (got === 1'b1)
                break;
        end
    endtask

    // sync request, sysref, release; count boundaries until alignment
    task automatic link(input logic [7:0] mfc, input logic [7:0] lcv);
        wr(ADDR_MF_CTRL, mfc);
        wr(ADDR_LINK_CTRL, lcv);
        want <= 1'b1;
        repeat (20) @(posedge mclk_in);
        req <= 1'b1;
        @(posedge mclk_in);
        req <= 1'b0;
        repeat (40) @(posedge mclk_in);
        want <= 1'b0;
        nb = 0;
        il = 1'b0;
        repeat (900)
        begin
            @(negedge mclk_in);
            if (bnd === 1'b1)
                nb++;
            if (got === 1'b1 && gs.is_k === 1'b1
                && (gs.data === CH_K280 || gs.data === CH_K283))
            begin
                il = 1'b1;
                c = cnt;
                break;
            end
            if (got === 1'b1 && gs.is_k === 1'b0)
                break;
        end
        @(posedge mclk_in);
    endtask

    task automatic conclude;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge mclk_in);
        num_errors++;
        conclude();
    end

    initial
    begin
        bus = '0;
        ce_in = 1'b1;
        rst_in = 1'b1;
        smp = 8'h5A;
        sv = 1'b1;
        {want, req, stall, slow} = 4'h0;
        repeat (2) @(posedge mclk_in);
        rst_in <= 1'b0;
        @(posedge mclk_in);
        foreach (rows[i])
        begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a, v);
            check({1'b0, v}, {1'b0, rows[i].r});
            if (rows[i].k == 1)
            begin
                repeat (8) nxt();
                nxt();
                check(gs, rows[i].s);
            end
            if (rows[i].k == 2)
            begin
                il = 1'b0;
                repeat (64)
                begin
                    nxt();
                    if (gs === {CH_K283, 1'b1} || gs === {CH_K280, 1'b1})
                        il = 1'b1;
                end
                check({8'h00, il}, 9'h001);
            end
            if (rows[i].k == 3)
            begin
                repeat (9) nxt();
                s0 = gs;
                repeat (6) nxt();
                check({8'h00, gs == s0}, 9'h000);
                repeat (6) nxt();
                check(gs, s0);
                check({7'h00, gs.is_k, flip}, 9'h001);
            end
        end
        wr(ADDR_TEST_PATTERN, 8'h00);
        // preset start, then mask set by sysref and cleared by write
        wr(ADDR_MF_CTRL, 8'hA8);
        req <= 1'b1;
        @(posedge mclk_in);
        req <= 1'b0;
        repeat (8) @(posedge mclk_in);
        rd(ADDR_STATUS, v);
        check({8'h00, v[2]}, 9'h001);
        wr(ADDR_TEST_PATTERN, 8'h08);
        rd(ADDR_STATUS, v);
        check({8'h00, v[2]}, 9'h000);
        slow <= 1'b1;
        link(8'h03, 8'h00);
        check({8'h00, il && nb >= 3 && nb <= 5}, 9'h001);
        slow <= 1'b0;
        link(8'h00, 8'h00);
        check({8'h00, il && nb <= 2}, 9'h001);
        link(8'h00, 8'h01);
        check(gs, {8'h5A, 1'b0});
        check({8'h00, il}, 9'h000);
        // fifo fills while the receiver stalls, then drains
        stall <= 1'b1;
        repeat (20) @(posedge mclk_in);
        @(negedge mclk_in);
        check({7'h00, svld, srdy}, 9'h002);
        stall <= 1'b0;
        sv <= 1'b0;
        repeat (20) @(posedge mclk_in);
        @(negedge mclk_in);
        check({8'h00, svld}, 9'h000);
        sv <= 1'b1;
        wr(ADDR_MF_LENGTH, 8'h1F);
        link(8'h00, 8'h80);
        check({8'h00, il && (c == 5'h1F || c <= 5'h01)}, 9'h001);
        rst_in <= 1'b1;
        repeat (2) @(posedge mclk_in);
        rst_in <= 1'b0;
        @(posedge mclk_in);
        foreach (rows[i])
        begin
            rd(rows[i].a, v);
            check({1'b0, v}, 9'h000);
        end
        conclude();
    end
endmodule
